// >>> ccmac_pkg.sv
// package for the chip configuration and memory access control registers
package ccmac_pkg;
  localparam logic [7:0] CCMAC_ADDR_CHIP_CFG = 8'h01;
  localparam logic [7:0] CCMAC_ADDR_MEM_ACC = 8'h02;
  // chip configuration bit positions
  localparam int CCMAC_CC_PLL_RDY = 7;
  localparam int CCMAC_CC_WAIT_MASK = 6;
  localparam int CCMAC_CC_KEYPAD = 5;
  localparam int CCMAC_CC_PANEL_LO = 3;
  localparam int CCMAC_CC_I2C = 2;
  localparam int CCMAC_CC_SPI = 1;
  localparam int CCMAC_CC_WIDTH16 = 0;
  // memory access control bit positions
  localparam int CCMAC_MA_FMT_LO = 6;
  localparam int CCMAC_MA_RDIR_LO = 4;
  localparam int CCMAC_MA_WDIR_LO = 1;
  // reset values
  localparam logic [7:0] CCMAC_CC_RESET = 8'h48;
  localparam logic [7:0] CCMAC_MA_RESET = 8'h00;
  // writable bits of memory access control: bits 3 and 0 read zero
  localparam logic [7:0] CCMAC_MA_WMASK = 8'hF6;
  // bit 7 of chip configuration is status only, never stored
  localparam logic [7:0] CCMAC_CC_WMASK = 8'h7F;
  // read data when no read is answered
  localparam logic [7:0] CCMAC_RD_IDLE = 8'h00;
  localparam logic CCMAC_EVEN_RESET = 1'b1;
  localparam logic CCMAC_CS_N_IDLE = 1'b1;

  typedef enum logic [1:0] {
    CCMAC_PANEL_24 = 2'b00,
    CCMAC_PANEL_18 = 2'b01,
    CCMAC_PANEL_16 = 2'b10,
    CCMAC_PANEL_OFF = 2'b11
  } ccmac_panel_e;

  typedef enum logic [1:0] {
    CCMAC_SCAN_LR_TB = 2'b00,
    CCMAC_SCAN_RL_TB = 2'b01,
    CCMAC_SCAN_TB_LR = 2'b10,
    CCMAC_SCAN_BT_LR = 2'b11
  } ccmac_scan_e;

  // format: 0x = direct, 10 = mask every high byte, 11 = mask even high bytes
  localparam logic [1:0] CCMAC_FMT_MASK_ALL = 2'b10;
  localparam logic [1:0] CCMAC_FMT_MASK_EVEN = 2'b11;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccmac_bus_s;

  typedef struct packed {
    logic i2c_on_kp0;
    logic keypad_en;
    logic spi_en;
    logic [1:0] panel_mode;
    logic [2:0] panel_gpio_bytes;
  } ccmac_pins_s;

  typedef struct packed {
    logic [7:0] chip_configuration;
    logic [7:0] memory_access_control;
    logic [7:0] rdata;
    logic even_word;
    logic cs_n_meta;
    logic cs_n_sync;
  } ccmac_state_s;
endpackage

// >>> ccmac_regs.sv
// chip configuration and memory access control register bank
//
// Contract
// [R1] pll ready bit reads 1 after clock switched to pll, else 0
// [R2] wait mask 0: stall held while busy, whatever chip select does
// [R3] wait mask 1 (reset): stall released while chip select deasserted
// [R4] host that cannot stretch cycles polls stall high before next access
// [R5] panel field: 00 24bit, 01 18bit reset, 10 16bit, 11 none
// [R6] i2c enable routes pins to i2c master, resets to 0
// [R7] i2c and keypad both on: keypad pins 0 carry i2c, rest keypad
// [R8] flash enable routes pins to spi master, resets to 0
// [R9] width bit: 0 gives 8-bit host bus, 1 gives 16-bit
// [R10] serial host or initial display forces width bit 0
// [R11] format 0x means direct write of image data
// [R12] format 10 drops high byte of every image data word
// [R13] format 11 drops high byte of even image data words only
// [R14] graphic mode read direction field orders pixel reads
// [R15] graphic mode write direction field orders pixel writes
// [R16] direction fields ignored in linear addressing mode
// [R17] memory access control bits 0 and 3 read zero
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module ccmac_regs
  import ccmac_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire ccmac_bus_s bus,
  output logic [7:0] rdata,
  // core status, same clock
  input wire logic pll_switched,
  input wire logic core_busy,
  input wire logic serial_host,
  input wire logic init_display,
  input wire logic linear_mode,
  // host chip select pin, active low
  input wire logic host_cs_n,
  // host stall output, active low
  output logic host_wait_n,
  // image data path
  input wire logic img_valid,
  input wire logic img_first,
  input wire logic [15:0] img_in,
  output logic [15:0] img_out,
  // configuration outputs
  output logic host_bus16,
  output ccmac_pins_s pins,
  output ccmac_scan_e rd_scan,
  output ccmac_scan_e wr_scan
);

  ccmac_state_s st, next_st;
  logic [7:0] cc_view;
  logic force8;
  logic [1:0] fmt;
  logic next_even;

  // serial host and initial display only ever move bytes
  assign force8 = serial_host | init_display; // R10

  always_comb begin
    cc_view = st.chip_configuration;
    cc_view[CCMAC_CC_PLL_RDY] = pll_switched; // R1
    if (force8) begin
      cc_view[CCMAC_CC_WIDTH16] = 1'b0; // R10
    end
  end

  always_comb begin
    next_st = st;
    if (bus.wr && bus.addr == CCMAC_ADDR_CHIP_CFG) begin
      // pll ready is status only, so bit 7 is never stored
      next_st.chip_configuration = bus.wdata & CCMAC_CC_WMASK; // R1
    end
    if (bus.wr && bus.addr == CCMAC_ADDR_MEM_ACC) begin
      next_st.memory_access_control = bus.wdata & CCMAC_MA_WMASK; // R17
    end
    next_st.rdata = CCMAC_RD_IDLE;
    if (bus.rd) begin
      case (bus.addr)
        CCMAC_ADDR_CHIP_CFG: next_st.rdata = cc_view;
        CCMAC_ADDR_MEM_ACC: next_st.rdata = st.memory_access_control; // R17
        default: next_st.rdata = CCMAC_RD_IDLE;
      endcase
    end
    // even/odd word tracking for masked formats, first word counts as even
    if (img_valid) begin
      next_st.even_word = next_even; // R13
    end
    // host chip select pin passes two flops before any logic reads it
    next_st.cs_n_meta = host_cs_n;
    next_st.cs_n_sync = st.cs_n_meta;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st.chip_configuration <= CCMAC_CC_RESET; // R5 R6 R8 R9 R3
      st.memory_access_control <= CCMAC_MA_RESET;
      st.rdata <= CCMAC_RD_IDLE;
      st.even_word <= CCMAC_EVEN_RESET;
      st.cs_n_meta <= CCMAC_CS_N_IDLE;
      st.cs_n_sync <= CCMAC_CS_N_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;

  // stall: busy drives it low; masked mode releases it outside chip select
  always_comb begin
    if (st.chip_configuration[CCMAC_CC_WAIT_MASK] && st.cs_n_sync) begin
      host_wait_n = 1'b1; // R3
    end else begin
      host_wait_n = ~core_busy; // R2 R4
    end
  end

  assign host_bus16 = cc_view[CCMAC_CC_WIDTH16]; // R9 R10

  function automatic logic [2:0] ccmac_unused_bytes(input logic [1:0] mode);
    case (mode)
      CCMAC_PANEL_24: ccmac_unused_bytes = 3'b000;
      CCMAC_PANEL_18: ccmac_unused_bytes = 3'b000;
      CCMAC_PANEL_16: ccmac_unused_bytes = 3'b100;
      default: ccmac_unused_bytes = 3'b111;
    endcase
  endfunction

  always_comb begin
    pins.panel_mode = st.chip_configuration[CCMAC_CC_PANEL_LO +: 2]; // R5
    // unused panel lanes fall back to gpio or keypad scan
    pins.panel_gpio_bytes = ccmac_unused_bytes(pins.panel_mode); // R5
    pins.spi_en = st.chip_configuration[CCMAC_CC_SPI]; // R8
    pins.keypad_en = st.chip_configuration[CCMAC_CC_KEYPAD];
    // i2c wins keypad_input_0 and keypad_output_0; low means gpio
    pins.i2c_on_kp0 = st.chip_configuration[CCMAC_CC_I2C]; // R6 R7
  end

  // linear mode forces the plain raster order
  always_comb begin
    if (linear_mode) begin
      rd_scan = CCMAC_SCAN_LR_TB; // R16
      wr_scan = CCMAC_SCAN_LR_TB; // R16
    end else begin
      rd_scan = ccmac_scan_e'(st.memory_access_control[CCMAC_MA_RDIR_LO +: 2]); // R14
      wr_scan = ccmac_scan_e'(st.memory_access_control[CCMAC_MA_WDIR_LO +: 2]); // R15
    end
  end

  assign fmt = st.memory_access_control[CCMAC_MA_FMT_LO +: 2];
  assign next_even = img_first ? 1'b1 : ~st.even_word;

  always_comb begin
    img_out = img_in; // R11
    if (fmt == CCMAC_FMT_MASK_ALL) begin
      img_out = {8'h00, img_in[7:0]}; // R12
    end else if (fmt == CCMAC_FMT_MASK_EVEN && next_even) begin
      img_out = {8'h00, img_in[7:0]}; // R13
    end
  end

  // assertions
  property p_pll_ready;
    @(posedge sys_clk) disable iff (sys_rst)
      bus.rd && bus.addr == CCMAC_ADDR_CHIP_CFG |=> rdata[CCMAC_CC_PLL_RDY] == $past(pll_switched);
  endproperty
  a_pll_ready: assert property (p_pll_ready) else $error("pll ready bit wrong"); // R1

  property p_wait_busy;
    @(posedge sys_clk) disable iff (sys_rst)
      !st.chip_configuration[CCMAC_CC_WAIT_MASK] && core_busy |-> !host_wait_n;
  endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("stall not held while busy"); // R2

  property p_wait_mask;
    @(posedge sys_clk) disable iff (sys_rst)
      st.chip_configuration[CCMAC_CC_WAIT_MASK] && st.cs_n_sync |-> host_wait_n;
  endproperty
  a_wait_mask: assert property (p_wait_mask) else $error("stall not released"); // R3

  property p_width_force;
    @(posedge sys_clk) disable iff (sys_rst) force8 |-> !host_bus16;
  endproperty
  a_width_force: assert property (p_width_force) else $error("bus width not forced"); // R10

  property p_mask_all;
    @(posedge sys_clk) disable iff (sys_rst)
      fmt == CCMAC_FMT_MASK_ALL |-> img_out[15:8] == 8'h00;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("high byte not masked"); // R12

  property p_direct;
    @(posedge sys_clk) disable iff (sys_rst) !fmt[1] |-> img_out == img_in;
  endproperty
  a_direct: assert property (p_direct) else $error("direct write altered data"); // R11

  property p_linear;
    @(posedge sys_clk) disable iff (sys_rst)
      linear_mode |-> rd_scan == CCMAC_SCAN_LR_TB && wr_scan == CCMAC_SCAN_LR_TB;
  endproperty
  a_linear: assert property (p_linear) else $error("direction not ignored"); // R16

  sequence s_ma_write;
    bus.wr && bus.addr == CCMAC_ADDR_MEM_ACC;
  endsequence
  sequence s_ma_read;
    bus.rd && bus.addr == CCMAC_ADDR_MEM_ACC;
  endsequence
  property p_ma_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      s_ma_read |=> rdata[3] == 1'b0 && rdata[0] == 1'b0;
  endproperty
  a_ma_zero: assert property (p_ma_zero) else $error("reserved bits not zero"); // R17

  property p_ma_write;
    @(posedge sys_clk) disable iff (sys_rst)
      s_ma_write |=> st.memory_access_control == ($past(bus.wdata) & CCMAC_MA_WMASK);
  endproperty
  a_ma_write: assert property (p_ma_write) else $error("reserved bits stored"); // R17

  property p_reset_panel;
    @(posedge sys_clk) $fell(sys_rst) |-> pins.panel_mode == CCMAC_PANEL_18 && !pins.i2c_on_kp0;
  endproperty
  a_reset_panel: assert property (p_reset_panel) else $error("bad reset value"); // R5

  property p_reset_state;
    @(posedge sys_clk) $fell(sys_rst) |-> st.chip_configuration == CCMAC_CC_RESET
      && st.memory_access_control == CCMAC_MA_RESET && rdata == CCMAC_RD_IDLE;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad register reset"); // R3

  // register port: read data stands one cycle, then rests at zero
  property p_rdata_idle;
    @(posedge sys_clk) disable iff (sys_rst)
      !bus.rd |=> rdata == CCMAC_RD_IDLE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  sequence s_unmapped_read;
    bus.rd && bus.addr != CCMAC_ADDR_CHIP_CFG && bus.addr != CCMAC_ADDR_MEM_ACC;
  endsequence
  property p_unmapped;
    @(posedge sys_clk) disable iff (sys_rst)
      s_unmapped_read |=> rdata == CCMAC_RD_IDLE;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address read nonzero");

  sequence s_cc_write;
    bus.wr && bus.addr == CCMAC_ADDR_CHIP_CFG;
  endsequence
  property p_cc_write;
    @(posedge sys_clk) disable iff (sys_rst)
      s_cc_write |=> st.chip_configuration == ($past(bus.wdata) & CCMAC_CC_WMASK);
  endproperty
  a_cc_write: assert property (p_cc_write) else $error("configuration write lost"); // R9

  property p_pll_store;
    @(posedge sys_clk) disable iff (sys_rst)
      !st.chip_configuration[CCMAC_CC_PLL_RDY];
  endproperty
  a_pll_store: assert property (p_pll_store) else $error("status bit stored"); // R1

  // stall: only a busy core may pull it low
  property p_wait_free;
    @(posedge sys_clk) disable iff (sys_rst)
      !core_busy |-> host_wait_n;
  endproperty
  a_wait_free: assert property (p_wait_free) else $error("stall without busy"); // R2

  // chip select reaches the stall logic two edges after the pin moves
  sequence s_cs_fall;
    $fell(host_cs_n) ##1 !host_cs_n;
  endsequence
  property p_cs_sync;
    @(posedge sys_clk) disable iff (sys_rst)
      s_cs_fall |=> !st.cs_n_sync;
  endproperty
  a_cs_sync: assert property (p_cs_sync) else $error("chip select not synchronised"); // R3

  property p_width16;
    @(posedge sys_clk) disable iff (sys_rst)
      !force8 |-> host_bus16 == st.chip_configuration[CCMAC_CC_WIDTH16];
  endproperty
  a_width16: assert property (p_width16) else $error("bus width not from register"); // R9

  // pin routing
  property p_panel_16;
    @(posedge sys_clk) disable iff (sys_rst)
      pins.panel_mode == CCMAC_PANEL_16 |-> pins.panel_gpio_bytes == 3'b100;
  endproperty
  a_panel_16: assert property (p_panel_16) else $error("16 bit lanes not freed"); // R5

  property p_panel_off;
    @(posedge sys_clk) disable iff (sys_rst)
      pins.panel_mode == CCMAC_PANEL_OFF |-> pins.panel_gpio_bytes == 3'b111;
  endproperty
  a_panel_off: assert property (p_panel_off) else $error("panel lanes not freed"); // R5

  property p_i2c_wins;
    @(posedge sys_clk) disable iff (sys_rst)
      st.chip_configuration[CCMAC_CC_I2C] && st.chip_configuration[CCMAC_CC_KEYPAD]
        |-> pins.i2c_on_kp0 && pins.keypad_en;
  endproperty
  a_i2c_wins: assert property (p_i2c_wins) else $error("i2c did not win pin 0"); // R7

  property p_rd_scan;
    @(posedge sys_clk) disable iff (sys_rst)
      !linear_mode |-> rd_scan == st.memory_access_control[CCMAC_MA_RDIR_LO +: 2];
  endproperty
  a_rd_scan: assert property (p_rd_scan) else $error("read direction wrong"); // R14

  property p_wr_scan;
    @(posedge sys_clk) disable iff (sys_rst)
      !linear_mode |-> wr_scan == st.memory_access_control[CCMAC_MA_WDIR_LO +: 2];
  endproperty
  a_wr_scan: assert property (p_wr_scan) else $error("write direction wrong"); // R15

  // image word parity
  sequence s_img_first;
    img_valid && img_first;
  endsequence
  sequence s_img_next;
    img_valid && !img_first;
  endsequence
  property p_parity_first;
    @(posedge sys_clk) disable iff (sys_rst)
      s_img_first |=> st.even_word;
  endproperty
  a_parity_first: assert property (p_parity_first) else $error("first word not even"); // R13

  property p_parity_next;
    @(posedge sys_clk) disable iff (sys_rst)
      s_img_next |=> st.even_word != $past(st.even_word);
  endproperty
  a_parity_next: assert property (p_parity_next) else $error("word parity stuck"); // R13

  property p_mask_even;
    @(posedge sys_clk) disable iff (sys_rst)
      fmt == CCMAC_FMT_MASK_EVEN && next_even |-> img_out[15:8] == 8'h00;
  endproperty
  a_mask_even: assert property (p_mask_even) else $error("even word not masked"); // R13

  property p_odd_pass;
    @(posedge sys_clk) disable iff (sys_rst)
      fmt == CCMAC_FMT_MASK_EVEN && !next_even |-> img_out == img_in;
  endproperty
  a_odd_pass: assert property (p_odd_pass) else $error("odd word altered"); // R13

endmodule

// >>> ccmac_host_model.sv
// host microcontroller model driving the register port
`timescale 1ns/1ps
module ccmac_host_model
  import ccmac_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // host pins
  output ccmac_bus_s bus,
  output logic host_cs_n,
  input wire logic [7:0] rdata,
  input wire logic host_wait_n
);
  initial begin
    bus = '0;
    host_cs_n = 1'b1;
  end
  // cycles cannot be stretched, so wait for the stall to lift first
  task automatic poll;
    int n;
    n = 0;
    while (host_wait_n !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic sel(input logic v);
    host_cs_n <= v;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    poll();
    bus <= '{addr: a, wdata: (a == CCMAC_ADDR_MEM_ACC) ? (d & 8'hFE) : d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    bus.wdata <= ~bus.wdata;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    poll();
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask
endmodule

// >>> tb_ccmac_regs.sv
// testbench for the configuration register bank
`timescale 1ns/1ps
module tb_ccmac_regs;
  import ccmac_pkg::*;
  logic sys_clk = 0, sys_rst = 1, pll_switched = 0, core_busy = 0, serial_host = 0;
  logic init_display = 0, linear_mode = 0, img_valid = 0, img_first = 0;
  logic [15:0] img_in = 16'h0000;
  logic [7:0] r;
  int num_errors = 0, n_checks = 0;
  ccmac_bus_s bus;
  logic host_cs_n, host_wait_n, host_bus16;
  logic [7:0] rdata;
  logic [15:0] img_out;
  ccmac_pins_s pins;
  ccmac_scan_e rd_scan, wr_scan;
  // address, write data, expected read back
  logic [23:0] rows [6] = '{24'h01_BF3F, 24'h01_0000, 24'h02_FFF6, 24'h02_0000,
    24'h03_AA00, 24'h01_4848};
  ccmac_regs i_ccmac_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .pll_switched(pll_switched), .core_busy(core_busy), .serial_host(serial_host),
    .init_display(init_display), .linear_mode(linear_mode), .host_cs_n(host_cs_n),
    .host_wait_n(host_wait_n), .img_valid(img_valid), .img_first(img_first),
    .img_in(img_in), .img_out(img_out), .host_bus16(host_bus16), .pins(pins),
    .rd_scan(rd_scan), .wr_scan(wr_scan));
  ccmac_host_model i_ccmac_host_model (.sys_clk(sys_clk), .bus(bus),
    .host_cs_n(host_cs_n), .rdata(rdata), .host_wait_n(host_wait_n));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    i_ccmac_host_model.wr(a, d);
    i_ccmac_host_model.rd(a, r);
    chk(r, e);
  endtask
  task automatic img(input logic f, input logic [15:0] e);
    img_first <= f;
    img_valid <= 1;
    img_in <= 16'hABCD;
    #5 chk(img_out, e);
    @(posedge sys_clk);
  endtask
  // whole run is about a hundred cycles
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    chk(pins.panel_mode, 2'b01);
    chk({pins.i2c_on_kp0, pins.spi_en, host_bus16}, 3'b000);
    i_ccmac_host_model.rd(CCMAC_ADDR_CHIP_CFG, r);
    chk(r, 8'h48);
    foreach (rows[i]) begin
      wrd(rows[i][23:16], rows[i][15:8], rows[i][7:0]);
      if (rows[i][23:16] == 8'h01)
        chk({pins.i2c_on_kp0, pins.keypad_en, pins.spi_en, host_bus16}, {4{rows[i][8]}});
    end
    for (int i = 0; i < 4; i++) begin
      i_ccmac_host_model.wr(CCMAC_ADDR_CHIP_CFG, 8'h40 | 8'(i << 3));
      i_ccmac_host_model.wr(CCMAC_ADDR_MEM_ACC, 8'(i * 18));
      chk(pins.panel_mode, i[1:0]);
      chk(pins.panel_gpio_bytes, (i == 3) ? 3'b111 : ((i == 2) ? 3'b100 : 3'b000));
      chk({rd_scan, wr_scan}, {2{i[1:0]}});
      linear_mode <= 1;
      @(posedge sys_clk);
      chk({rd_scan, wr_scan}, 4'h0);
      linear_mode <= 0;
    end
    pll_switched <= 1;
    @(posedge sys_clk);
    wrd(CCMAC_ADDR_CHIP_CFG, 8'h49, 8'hC9);
    chk(host_bus16, 1'b1);
    serial_host <= 1;
    @(posedge sys_clk);
    chk(host_bus16, 1'b0);
    serial_host <= 0;
    init_display <= 1;
    @(posedge sys_clk);
    chk(host_bus16, 1'b0);
    init_display <= 0;
    core_busy <= 1;
    repeat (3) @(posedge sys_clk);
    chk(host_wait_n, 1'b1);
    i_ccmac_host_model.sel(0);
    repeat (4) @(posedge sys_clk);
    chk(host_wait_n, 1'b0);
    i_ccmac_host_model.sel(1);
    core_busy <= 0;
    // mask off: stall must follow busy whatever chip select does
    i_ccmac_host_model.wr(CCMAC_ADDR_CHIP_CFG, 8'h08);
    core_busy <= 1;
    repeat (4) @(posedge sys_clk);
    chk(host_wait_n, 1'b0);
    i_ccmac_host_model.sel(0);
    repeat (3) @(posedge sys_clk);
    chk(host_wait_n, 1'b0);
    i_ccmac_host_model.sel(1);
    core_busy <= 0;
    i_ccmac_host_model.wr(CCMAC_ADDR_MEM_ACC, 8'h80);
    img(1, 16'h00CD);
    img(0, 16'h00CD);
    i_ccmac_host_model.wr(CCMAC_ADDR_MEM_ACC, 8'hC0);
    img(1, 16'h00CD);
    img(0, 16'hABCD);
    img(0, 16'h00CD);
    i_ccmac_host_model.wr(CCMAC_ADDR_MEM_ACC, 8'h40);
    img(1, 16'hABCD);
    img_valid <= 0;
    // second reset in mid-run must bring both registers back
    sys_rst <= 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    chk({pins.panel_mode, host_bus16}, 3'b010);
    i_ccmac_host_model.rd(CCMAC_ADDR_MEM_ACC, r);
    chk(r, 8'h00);
    i_ccmac_host_model.rd(CCMAC_ADDR_CHIP_CFG, r);
    chk(r, 8'hC8);
    stop_test();
  end
endmodule
